// ==== rtl/drum_defs.svh ====
`ifndef DRUM_DEFS_SVH
`define DRUM_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DRUM_OFS_CTRL 8'h00
`define DRUM_OFS_CFG 8'h04
`define DRUM_OFS_STATUS 8'h08
`define DRUM_OFS_STEP_COUNT 8'h0C
`define DRUM_OFS_TIMER 8'h10
`define DRUM_OFS_PRESET 8'h14
`define DRUM_OFS_CUR_STEP 8'h18
`define DRUM_OFS_TABLE 8'h40

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DRUM_CTRL_RUN 0
`define DRUM_CTRL_START 1
`define DRUM_CTRL_JOG 2
`define DRUM_CTRL_RESET 3
`define DRUM_CFG_PRESET_LSB 0
`define DRUM_CFG_LAST_LSB 8
`define DRUM_PRESET_RST 5'h01
`define DRUM_LAST_RST 5'h10
`define DRUM_STEP_MIN 5'h01
`define DRUM_STEP_MAX 5'h10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DRUM_CLK_PERIOD_NS 10
`define DRUM_TICK_NS 10000000
`define DRUM_TICK_CYCLES (`DRUM_TICK_NS / `DRUM_CLK_PERIOD_NS)

`endif

// ==== rtl/drum_pkg.sv ====
package drum_pkg;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} state_t;

  // One step table entry
  typedef struct packed {
    logic use_time;
    logic use_event;
    logic [13:0] counts;
    logic [15:0] pattern;
  } step_cfg_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// ==== rtl/step_table_mem.sv ====
`timescale 1ns/100ps
module step_table_mem
(
  input wire logic i_core_clk,
  input wire logic [3:0] i_seq_addr,
  output logic [31:0] o_seq_data,
  input wire logic [3:0] i_bus_addr,
  input wire logic i_bus_we,
  input wire logic [3:0] i_bus_sel,
  input wire logic [31:0] i_bus_wdata,
  output logic [31:0] o_bus_rdata
);

  logic [31:0] mem [0:15];

  // ----------------------------------------------------------------
  // Byte-lane write, two registered read ports
  // ----------------------------------------------------------------
  // No reset: contents are software's to load before run
  always_ff @(posedge i_core_clk)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (i_bus_we && i_bus_sel[b])
        mem[i_bus_addr][b*8 +: 8] <= i_bus_wdata[b*8 +: 8];
    end
    o_seq_data <= mem[i_seq_addr];
    o_bus_rdata <= mem[i_bus_addr];
  end

endmodule

// ==== rtl/tick_timer.sv ====
`timescale 1ns/100ps
module tick_timer
#(
  parameter int TICK_CYCLES = 1000000
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_clear,
  output logic [19:0] o_value,
  output logic o_tick
);

  localparam logic [19:0] LAST = 20'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Hundredth-second prescaler
  // ----------------------------------------------------------------
  // Holds its value while stopped so a paused step resumes mid-tick
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_value <= 20'h00000;
      o_tick <= 1'b0;
    end
    else if (i_clear)
    begin
      o_value <= 20'h00000;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= i_run && (o_value == LAST);
      if (i_run)
        o_value <= (o_value == LAST) ? 20'h00000 : o_value + 20'h00001;
    end
  end

endmodule

// ==== rtl/drum_seq.sv ====
// How it works
// - Entering run mode loads the current step with the preset step.
// - With start high and reset low the step runs its event and timer.
// - Reset beats start and sends the sequencer to the preset step.
// - Held reset keeps the preset step, timer stopped, events ignored.
// - Start low freezes the timer; counting resumes from there.
// - Last step finishing sets the done flag; step number stays put.
// - Reset from the done state clears the flag and loads preset.
// - Each jog rising edge advances one step, start high or low, reset low.
// - Jog advance clears the timer; with start high the new step runs.
// - Jog in the last step moves to done and sets the done flag.
// - Outputs follow the step while running; preset pattern at run entry.
// - Every step has its own programmed count length.
// - Step count, timer, preset and current step read as four counters.
// - Timer ticks every hundredth second; each tick adds one count.
// - Preset step is a number from one to sixteen.
// - Expired count advances to the next step and switches its pattern.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "drum_defs.svh"
module drum_seq
#(
  parameter int TICK_CYCLES = `DRUM_TICK_CYCLES
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire drum_pkg::wb_req_t i_wb,
  input wire logic [15:0] i_event,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output logic [15:0] o_step_out,
  output logic o_cycle_done_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-enable merge for software writes
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // Step number is legal only inside one to sixteen
  function automatic logic step_ok(input logic [4:0] s);
    return (s >= `DRUM_STEP_MIN) && (s <= `DRUM_STEP_MAX);
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic phase;
  logic [3:0] ctrl;
  logic [4:0] preset_step;
  logic [4:0] last_step;
  logic [15:0] counts_in_step;
  logic [4:0] cur_step;
  drum_pkg::state_t state;
  logic [31:0] tbl_bus_rdata;
  logic [19:0] tick_value;

  wire req = i_wb.cyc && i_wb.stb;
  wire wr_now = req && o_wb_ack && i_wb.we;
  wire tbl_hit = (i_wb.adr[7:6] == 2'(`DRUM_OFS_TABLE >> 6));
  wire ctrl_wr = wr_now && (i_wb.adr == `DRUM_OFS_CTRL);
  wire cfg_wr = wr_now && (i_wb.adr == `DRUM_OFS_CFG);
  wire tbl_wr = wr_now && tbl_hit;
  wire [31:0] cfg_word = {19'h00000, last_step, 3'h0, preset_step};
  wire [31:0] cfg_merged = merge_sel(cfg_word, i_wb.dat, i_wb.sel);
  wire [31:0] ctrl_merged = merge_sel({28'h0000000, ctrl}, i_wb.dat, i_wb.sel);
  wire [4:0] new_preset = cfg_merged[`DRUM_CFG_PRESET_LSB +: 5];
  wire [4:0] new_last = cfg_merged[`DRUM_CFG_LAST_LSB +: 5];

  // Read mux; unmapped offsets read as zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (tbl_hit)
      rd_mux = tbl_bus_rdata;
    else
    begin
      case (i_wb.adr)
        `DRUM_OFS_CTRL: rd_mux = {28'h0000000, ctrl};
        `DRUM_OFS_CFG: rd_mux = cfg_word;
        `DRUM_OFS_STATUS: rd_mux = {29'h00000000, state, o_cycle_done_flag};
        `DRUM_OFS_STEP_COUNT: rd_mux = {16'h0000, counts_in_step};
        `DRUM_OFS_TIMER: rd_mux = {12'h000, tick_value};
        `DRUM_OFS_PRESET: rd_mux = {27'h0000000, preset_step};
        `DRUM_OFS_CUR_STEP: rd_mux = {27'h0000000, cur_step};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Ack on the third cycle so table reads see registered data
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      phase <= req && !phase && !o_wb_ack;
      o_wb_ack <= req && phase && !o_wb_ack;
      if (req && phase && !o_wb_ack)
        o_wb_dat <= rd_mux;
    end
  end

  // Control and configuration; illegal step numbers are dropped
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl <= 4'h0;
      preset_step <= `DRUM_PRESET_RST;
      last_step <= `DRUM_LAST_RST;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= ctrl_merged[3:0];
      if (cfg_wr && step_ok(new_preset))
        preset_step <= new_preset;
      if (cfg_wr && step_ok(new_last))
        last_step <= new_last;
    end
  end

  // ----------------------------------------------------------------
  // Step control
  // ----------------------------------------------------------------
  wire ctrl_run = ctrl[`DRUM_CTRL_RUN];
  wire ctrl_start = ctrl[`DRUM_CTRL_START];
  wire ctrl_jog = ctrl[`DRUM_CTRL_JOG];
  wire ctrl_reset = ctrl[`DRUM_CTRL_RESET];
  logic run_prev;
  logic jog_prev;
  logic tick;
  logic [31:0] seq_word;
  drum_pkg::step_cfg_t step_cfg;
  drum_pkg::state_t next_state;
  logic [4:0] next_step;
  assign step_cfg = drum_pkg::step_cfg_t'(seq_word);

  wire [3:0] cur_idx = 4'(cur_step - 5'h01);
  wire [3:0] next_idx = 4'(next_step - 5'h01);
  wire run_rise = ctrl_run && !run_prev;
  wire jog_rise = ctrl_jog && !jog_prev;
  wire in_run = (state == drum_pkg::ST_RUN) && ctrl_run && !run_rise;
  wire step_event = i_event[cur_idx];
  wire running = in_run && ctrl_start && !ctrl_reset;
  // Event gates the timer when both are set up
  wire timer_en = running && step_cfg.use_time && (!step_cfg.use_event || step_event);
  wire time_met = counts_in_step >= {2'h0, step_cfg.counts};
  wire cond_met = step_cfg.use_time ? time_met : (!step_cfg.use_event || step_event);
  wire step_adv = running && cond_met;
  wire jog_adv = in_run && !ctrl_reset && jog_rise;
  wire advance = step_adv || jog_adv;
  wire at_last = (cur_step == last_step) || (cur_step == `DRUM_STEP_MAX);
  wire clear_counts = run_rise || (ctrl_run && ctrl_reset) || (in_run && advance);

  // Next state and step
  always_comb
  begin
    next_state = state;
    next_step = cur_step;
    if (!ctrl_run)
      next_state = drum_pkg::ST_IDLE;
    else if (run_rise || ctrl_reset)
    begin
      next_state = drum_pkg::ST_RUN;
      next_step = preset_step;
    end
    else
    begin
      case (state)
        drum_pkg::ST_RUN:
        begin
          if (advance && at_last)
            next_state = drum_pkg::ST_DONE;
          else if (advance)
            next_step = cur_step + 5'h01;
        end
        drum_pkg::ST_DONE: next_state = drum_pkg::ST_DONE;
        default: next_state = drum_pkg::ST_IDLE;
      endcase
    end
  end

  // Pattern memory is read at the next step so it lines up with it
  step_table_mem u_table
  (
    .i_core_clk(i_core_clk),
    .i_seq_addr(next_idx),
    .o_seq_data(seq_word),
    .i_bus_addr(i_wb.adr[5:2]),
    .i_bus_we(tbl_wr),
    .i_bus_sel(i_wb.sel),
    .i_bus_wdata(i_wb.dat),
    .o_bus_rdata(tbl_bus_rdata)
  );

  tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_run(timer_en),
    .i_clear(clear_counts),
    .o_value(tick_value),
    .o_tick(tick)
  );

  // Sequencer registers
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= drum_pkg::ST_IDLE;
      cur_step <= `DRUM_PRESET_RST;
      run_prev <= 1'b0;
      jog_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur_step <= next_step;
      run_prev <= ctrl_run;
      jog_prev <= ctrl_jog;
    end
  end

  // Counts in step; tick lands a cycle late so it is gated again
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      counts_in_step <= 16'h0000;
    else if (clear_counts)
      counts_in_step <= 16'h0000;
    else if (tick && running)
      counts_in_step <= counts_in_step + 16'h0001;
  end

  // Done flag and outputs; outputs dark only outside run mode
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cycle_done_flag <= 1'b0;
      o_step_out <= 16'h0000;
    end
    else
    begin
      o_cycle_done_flag <= (next_state == drum_pkg::ST_DONE);
      o_step_out <= (state != drum_pkg::ST_IDLE) ? step_cfg.pattern : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_run_entry: assert property (run_rise |=> cur_step == $past(preset_step))
    else $error("run entry did not load preset step");
  chk_reset_priority: assert property (ctrl_run && ctrl_reset && ctrl_start
    |=> state == drum_pkg::ST_RUN && cur_step == $past(preset_step))
    else $error("reset did not win over start");
  chk_reset_hold: assert property ((ctrl_run && ctrl_reset) [*3]
    |=> counts_in_step == 16'h0000 && cur_step == $past(preset_step))
    else $error("held reset let the step run");
  chk_start_freeze: assert property (in_run && !ctrl_start && !jog_rise && !ctrl_reset
    ##1 ctrl_run |-> $stable(counts_in_step) && $stable(tick_value))
    else $error("timer moved while start was low");
  chk_last_done: assert property (in_run && !ctrl_reset && advance && at_last
    |=> o_cycle_done_flag && cur_step == $past(cur_step) ##1 o_cycle_done_flag || !ctrl_run
    || ctrl_reset)
    else $error("last step did not complete the cycle");
  chk_done_clear: assert property (state == drum_pkg::ST_DONE && ctrl_run && ctrl_reset
    |=> !o_cycle_done_flag && cur_step == $past(preset_step))
    else $error("reset from done did not clear flag");
  chk_jog_step: assert property (jog_adv && !at_last
    |=> cur_step == $past(cur_step) + 5'h01 && counts_in_step == 16'h0000)
    else $error("jog did not advance one step");
  chk_done_sticky: assert property (state == drum_pkg::ST_DONE && ctrl_run && !ctrl_reset
    |=> state == drum_pkg::ST_DONE && cur_step == $past(cur_step))
    else $error("start or jog left the done state");
  chk_preset_range: assert property (step_ok(preset_step) && step_ok(cur_step))
    else $error("step number out of range");
  chk_timed_advance: assert property (step_adv && !jog_adv && !at_last && step_cfg.use_time
    |-> counts_in_step >= {2'h0, step_cfg.counts} ##1 cur_step == $past(cur_step) + 5'h01)
    else $error("timed step advanced early");


  // ----------------------------------------------------------------
  // Output, bus, reset and event checks
  // ----------------------------------------------------------------
  // Outputs go dark once the sequencer leaves run mode
  chk_out_idle: assert property (state == drum_pkg::ST_IDLE |=> o_step_out == 16'h0000)
    else $error("outputs not dark outside run mode");
  // Ack is a single pulse; a request still held after it is acked again three cycles later
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held for two cycles");
  // No ack without a standing request
  chk_ack_req: assert property (!req |=> !o_wb_ack)
    else $error("ack without request");
  // Flag and state are set together
  chk_done_state: assert property (o_cycle_done_flag |-> state == drum_pkg::ST_DONE)
    else $error("done flag without done state");
  // Held reset keeps the prescaler at zero
  chk_timer_stop: assert property (ctrl_run && ctrl_reset |=> tick_value == 20'h00000)
    else $error("timer ran during reset");
  // Jog under reset only reloads the preset step
  chk_jog_reset: assert property (ctrl_run && ctrl_reset && jog_rise
    |=> cur_step == $past(preset_step))
    else $error("jog acted while reset was high");
  // Event-only step waits for its event
  chk_event_wait: assert property (running && step_cfg.use_event && !step_cfg.use_time
    && !step_event && !jog_rise |=> cur_step == $past(cur_step))
    else $error("event step advanced without event");

  cov_event_step: cover property (running && step_cfg.use_event && step_event);
  cov_done: cover property (state == drum_pkg::ST_RUN ##1 state == drum_pkg::ST_DONE);
  cov_jog: cover property (jog_adv && !ctrl_start);
  cov_reset_run: cover property (running ##1 ctrl_reset);
  cov_freeze: cover property (timer_en ##1 !ctrl_start ##1 ctrl_start);

endmodule

// ==== dv/host_bus_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Host program model on the register bus
// ----------------------------------------
module host_bus_model
(
  input wire logic i_core_clk,
  input wire logic i_wb_ack,
  input wire logic [31:0] i_wb_dat,
  output drum_pkg::wb_req_t o_wb
);
  initial o_wb = '0;

  // One classic cycle, held until ack is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_wb <= {1'b1, 1'b1, w, 4'hF, a, d};
    // Ack and read data are taken at the rising edge, before that edge updates them
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (i_wb_ack !== 1'b1 && n < 40);
    q = i_wb_dat;
    // Released lines show the inverse, so a stale value never looks valid
    o_wb <= {2'b00, ~w, 4'h0, ~a, ~d};
  endtask
endmodule

// ==== dv/test_drum_seq.sv ====
`timescale 1ns/100ps
module test_drum_seq;
  // Short tick keeps the run brief
  localparam int T = 10;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] i_event = 16'h0000;
  drum_pkg::wb_req_t wb;
  logic ack;
  logic [31:0] rdat;
  logic [15:0] step_out;
  logic done;
  logic [31:0] q;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;

  always #5 i_core_clk = ~i_core_clk;

  drum_seq #(.TICK_CYCLES(T)) drum_seq_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_wb(wb), .i_event(i_event), .o_wb_ack(ack), .o_wb_dat(rdat),
    .o_step_out(step_out), .o_cycle_done_flag(done));
  host_bus_model host_bus_model_i (.i_core_clk(i_core_clk), .i_wb_ack(ack),
    .i_wb_dat(rdat), .o_wb(wb));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, lo, (v >= lo && v <= hi) ? lo : v);
  endtask
  // Write lands at the ack edge; step settles one edge later, outputs two
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_bus_model_i.xfer(1'b1, a, d, q);
    repeat (3) @(negedge i_core_clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    host_bus_model_i.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // Cycles until the outputs leave a pattern, bounded
  task automatic wait_out(input logic [15:0] p);
    n = 0;
    while (step_out === p && n < 400)
    begin
      @(negedge i_core_clk);
      n++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    chk("out_idle", 32'h0, {16'h0, step_out});
    rdc("status", 8'h08, 32'h0);
    rdc("cur", 8'h18, 32'h1);
    rdc("unmapped", 8'h30, 32'h0);
    wr(8'h04, 32'h0000_1100);
    rdc("cfg_keep", 8'h04, 32'h0000_1001);
    rdc("preset", 8'h14, 32'h1);
    $display("test reset_vals done");
  endtask

  task automatic t_run_entry;
    wr(8'h40, 32'h8002_0000);
    wr(8'h44, 32'h8003_00A5);
    wr(8'h48, 32'h8005_5A00);
    wr(8'h4C, 32'h4000_F00F);
    rdc("table3", 8'h48, 32'h8005_5A00);
    wr(8'h04, 32'h0000_0402);
    wr(8'h00, 32'h1);
    rdc("cur", 8'h18, 32'h2);
    chk("out_preset", 32'h00A5, {16'h0, step_out});
    repeat (5 * T) @(negedge i_core_clk);
    chk("no_start", 32'h00A5, {16'h0, step_out});
    $display("test run_entry done");
  endtask

  task automatic t_timed;
    wr(8'h00, 32'h3);
    wait_out(16'h00A5);
    rng("step2_len", n, 3 * T - 2, 3 * T + 6);
    chk("out_next", 32'h5A00, {16'h0, step_out});
    repeat (2 * T) @(negedge i_core_clk);
    wr(8'h00, 32'h1);
    repeat (8 * T) @(negedge i_core_clk);
    chk("frozen", 32'h5A00, {16'h0, step_out});
    wr(8'h00, 32'h3);
    wait_out(16'h5A00);
    rng("resume_len", n, T, 4 * T);
    repeat (4 * T) @(negedge i_core_clk);
    chk("wait_event", 32'h0, {31'h0, done});
    @(posedge i_core_clk);
    i_event <= 16'h0008;
    repeat (6) @(negedge i_core_clk);
    chk("done", 32'h1, {31'h0, done});
    chk("out_last", 32'hF00F, {16'h0, step_out});
    rdc("cur_last", 8'h18, 32'h4);
    $display("test timed done");
  endtask

  task automatic t_reset_prio;
    wr(8'h00, 32'h7);
    chk("done_jog", 32'h1, {31'h0, done});
    rdc("cur_jog", 8'h18, 32'h4);
    @(posedge i_core_clk);
    i_event <= 16'hFFFF;
    wr(8'h00, 32'hB);
    chk("done_clr", 32'h0, {31'h0, done});
    rdc("cur_rst", 8'h18, 32'h2);
    repeat (5 * T) @(negedge i_core_clk);
    chk("held", 32'h00A5, {16'h0, step_out});
    rdc("cnt_rst", 8'h0C, 32'h0);
    wr(8'h00, 32'h3);
    wait_out(16'h00A5);
    rng("rerun_len", n, 3 * T - 2, 3 * T + 6);
    $display("test reset_prio done");
  endtask

  task automatic t_jog;
    @(posedge i_core_clk);
    i_event <= 16'h0000;
    wr(8'h00, 32'hB);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h5);
    wr(8'h00, 32'h5);
    rdc("cur_jog1", 8'h18, 32'h3);
    rdc("cnt_jog", 8'h0C, 32'h0);
    wr(8'h00, 32'h3);
    wr(8'h00, 32'h7);
    rdc("cur_jog2", 8'h18, 32'h4);
    chk("out_jog", 32'hF00F, {16'h0, step_out});
    wr(8'h00, 32'h3);
    wr(8'h00, 32'h7);
    chk("done_jog", 32'h1, {31'h0, done});
    rdc("cur_keep", 8'h18, 32'h4);
    $display("test jog done");
  endtask

  task automatic t_repeat;
    // Host ORs the done flag into reset for an endless cycle
    wr(8'h00, {28'h0, done, 3'b011});
    chk("rep_clr", 32'h0, {31'h0, done});
    rdc("rep_cur", 8'h18, 32'h2);
    wr(8'h00, 32'h0);
    repeat (3) @(negedge i_core_clk);
    chk("out_off", 32'h0, {16'h0, step_out});
    $display("test repeat done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles the tests need
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test;
    end
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset_vals;
    t_run_entry;
    t_timed;
    t_reset_prio;
    t_jog;
    t_repeat;
    stop_test;
  end
endmodule
